// ---- rtl/gpsh_pkg.sv ----
// Purpose: Constants and types for the GPIO strap and pin sharing block
// Assumes: APB with 32-bit data; one aligned word per register
// Notes:   Direction bit 1 means the pin is driven as an output
package gpsh_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] GPSH_OFF_PA_DATA = 8'h00;
    localparam logic [7:0] GPSH_OFF_PA_DIR  = 8'h04;
    localparam logic [7:0] GPSH_OFF_PB_DATA = 8'h08;
    localparam logic [7:0] GPSH_OFF_PB_DIR  = 8'h0c;
    localparam logic [7:0] GPSH_OFF_PD_DATA = 8'h10;
    localparam logic [7:0] GPSH_OFF_PD_DIR  = 8'h14;
    localparam logic [7:0] GPSH_OFF_PE_DATA = 8'h18;
    localparam logic [7:0] GPSH_OFF_PE_DIR  = 8'h1c;
    localparam logic [7:0] GPSH_OFF_SYSC2   = 8'h20;
    localparam logic [7:0] GPSH_OFF_LEDSEL  = 8'h24;
    localparam logic [7:0] GPSH_OFF_STRAP   = 8'h28;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         GPSH_SYSC2_CARD1 = 0;
    localparam int         GPSH_SYSC2_CARD2 = 1;
    localparam int         GPSH_LEDSEL_BIT  = 0;
    localparam int         GPSH_STRAP_DONE  = 8;
    localparam logic [7:0] GPSH_RST_BYTE    = 8'h00;
    localparam logic [2:0] GPSH_RST_PE      = 3'h0;
    localparam logic [1:0] GPSH_RST_SYSC2   = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GPSH_ST_SYNC1 = 2'b00,
        GPSH_ST_SYNC2 = 2'b01,
        GPSH_ST_CAP   = 2'b10,
        GPSH_ST_DONE  = 2'b11
    } gpsh_strap_state_e;

    typedef struct packed {
        logic [3:0] lcd_id;
        logic       boot_clk_opt;
        logic       pll_mode;
        logic [1:0] boot_width;
    } gpsh_strap_s;

    localparam gpsh_strap_s GPSH_RST_STRAP = '0;

endpackage : gpsh_pkg

// ---- rtl/gpsh_top.sv ----
// Purpose: GPIO ports A, B, D, E with card ready sharing, LED flasher
//          sharing and power-on strap capture, behind an APB slave
// Assumes: presetn is the power-on reset; pins are asynchronous
// Notes:   One wait state on every APB access
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gpsh_top
    import gpsh_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [7:0]  port_a_pins_in,
    output logic [7:0]       port_a_pins_out,
    output logic [7:0]       port_a_pins_oe_n,
    input  wire logic [7:0]  port_b_pins_in,
    output logic [7:0]       port_b_pins_out,
    output logic [7:0]       port_b_pins_oe_n,
    input  wire logic [7:0]  port_d_pins_in,
    output logic [7:0]       port_d_pins_out,
    output logic [7:0]       port_d_pins_oe_n,
    input  wire logic [2:0]  port_e_pins_in,
    output logic [2:0]       port_e_pins_out,
    output logic [2:0]       port_e_pins_oe_n,
    input  wire logic [3:0]  lcd_pins_in,
    output logic [3:0]       lcd_pins_out,
    output logic [3:0]       lcd_pins_oe_n,
    input  wire logic [3:0]  lcd_display_data,
    input  wire logic        led_flasher_output,
    output logic [1:0]       card_ready_input,
    output logic             port_a_card_ready,
    output logic [7:0]       keyboard_rows,
    output gpsh_strap_s      strap,
    output logic             strap_valid
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [30:0] sync1_r;
    logic [30:0] sync2_r;
    wire  [30:0] pins_raw = {lcd_pins_in, port_e_pins_in, port_d_pins_in,
                             port_b_pins_in, port_a_pins_in};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    wire [7:0] pa_s  = sync2_r[7:0];
    wire [7:0] pb_s  = sync2_r[15:8];
    wire [7:0] pd_s  = sync2_r[23:16];
    wire [2:0] pe_s  = sync2_r[26:24];
    wire [3:0] lcd_s = sync2_r[30:27];

    // ------------------------------------------------------------
    // Strap capture sequence
    // ------------------------------------------------------------
    gpsh_strap_state_e state_r;
    gpsh_strap_state_e state_nxt;
    gpsh_strap_s       strap_r;
    gpsh_strap_s       strap_nxt;
    wire               st_done = (state_r == GPSH_ST_DONE);
    wire               st_cap  = (state_r == GPSH_ST_CAP);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            GPSH_ST_SYNC1: state_nxt = GPSH_ST_SYNC2;
            GPSH_ST_SYNC2: state_nxt = GPSH_ST_CAP;
            GPSH_ST_CAP:   state_nxt = GPSH_ST_DONE;
            GPSH_ST_DONE:  state_nxt = GPSH_ST_DONE;
        endcase
    end

    always_comb begin
        strap_nxt = strap_r;
        if (st_cap) begin
            strap_nxt.boot_width   = pe_s[1:0];
            strap_nxt.pll_mode     = pe_s[2];
            strap_nxt.boot_clk_opt = pa_s[6];
            strap_nxt.lcd_id       = lcd_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= GPSH_ST_SYNC1;
            strap_r <= GPSH_RST_STRAP;
        end else begin
            state_r <= state_nxt;
            strap_r <= strap_nxt;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic [7:0] pa_data_r, pa_dir_r, pb_data_r, pb_dir_r;
    logic [7:0] pd_data_r, pd_dir_r;
    logic [2:0] pe_data_r, pe_dir_r;
    logic [1:0] sysc2_r;
    logic       ledsel_r;
    logic       pready_r;
    logic [31:0] prdata_r;
    logic       pslverr_r;

    wire        acc_req = psel & penable & ~pready_r;
    wire        wr_ev   = psel & penable & pready_r & pwrite;
    wire        hit_pad = (paddr == GPSH_OFF_PA_DATA);
    wire        hit_par = (paddr == GPSH_OFF_PA_DIR);
    wire        hit_pbd = (paddr == GPSH_OFF_PB_DATA);
    wire        hit_pbr = (paddr == GPSH_OFF_PB_DIR);
    wire        hit_pdd = (paddr == GPSH_OFF_PD_DATA);
    wire        hit_pdr = (paddr == GPSH_OFF_PD_DIR);
    wire        hit_ped = (paddr == GPSH_OFF_PE_DATA);
    wire        hit_per = (paddr == GPSH_OFF_PE_DIR);
    wire        hit_sc2 = (paddr == GPSH_OFF_SYSC2);
    wire        hit_led = (paddr == GPSH_OFF_LEDSEL);
    wire        hit_stp = (paddr == GPSH_OFF_STRAP);
    wire        hit_any = hit_pad | hit_par | hit_pbd | hit_pbr | hit_pdd | hit_pdr
                        | hit_ped | hit_per | hit_sc2 | hit_led | hit_stp;
    wire        err_nxt = ~hit_any | (pwrite & hit_stp);

    // Data registers read back the pin level
    wire [31:0] rd_mux =
          hit_pad ? {24'h0, pa_s}
        : hit_par ? {24'h0, pa_dir_r}
        : hit_pbd ? {24'h0, pb_s}
        : hit_pbr ? {24'h0, pb_dir_r}
        : hit_pdd ? {24'h0, pd_s}
        : hit_pdr ? {24'h0, pd_dir_r}
        : hit_ped ? {29'h0, pe_s}
        : hit_per ? {29'h0, pe_dir_r}
        : hit_sc2 ? {30'h0, sysc2_r}
        : hit_led ? {31'h0, ledsel_r}
        : hit_stp ? {23'h0, st_done, strap_r}
        : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc_req;
            prdata_r  <= acc_req ? rd_mux : 32'h0;
            pslverr_r <= acc_req & err_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_data_r <= GPSH_RST_BYTE;
            pa_dir_r  <= GPSH_RST_BYTE;
            pb_data_r <= GPSH_RST_BYTE;
            pb_dir_r  <= GPSH_RST_BYTE;
            pd_data_r <= GPSH_RST_BYTE;
            pd_dir_r  <= GPSH_RST_BYTE;
            pe_data_r <= GPSH_RST_PE;
            pe_dir_r  <= GPSH_RST_PE;
            sysc2_r   <= GPSH_RST_SYSC2;
            ledsel_r  <= 1'b0;
        end else if (wr_ev) begin
            if (hit_pad) pa_data_r <= pwdata[7:0];
            if (hit_par) pa_dir_r  <= pwdata[7:0];
            if (hit_pbd) pb_data_r <= pwdata[7:0];
            if (hit_pbr) pb_dir_r  <= pwdata[7:0];
            if (hit_pdd) pd_data_r <= pwdata[7:0];
            if (hit_pdr) pd_dir_r  <= pwdata[7:0];
            if (hit_ped) pe_data_r <= pwdata[2:0];
            if (hit_per) pe_dir_r  <= pwdata[2:0];
            if (hit_sc2) sysc2_r   <= pwdata[1:0];
            if (hit_led) ledsel_r  <= pwdata[GPSH_LEDSEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Pin drive and shared functions
    // ------------------------------------------------------------
    // port B GPIO
    wire [7:0] pb_oe_nxt = ~(pb_dir_r & {6'h3f, ~sysc2_r});
    wire [2:0] pe_oe_nxt = st_done ? ~pe_dir_r : 3'h7;
    // flasher on port D bit 0
    wire [7:0] pd_out_nxt = {pd_data_r[7:1], ledsel_r ? led_flasher_output : pd_data_r[0]};
    wire [7:0] pd_oe_nxt  = ~(pd_dir_r | {7'h0, ledsel_r});
    wire [3:0] lcd_oe_nxt = st_done ? 4'h0 : 4'hf;
    wire [1:0] card_nxt = sysc2_r & pb_s[1:0];

    logic [7:0] pa_out_r, pa_oe_r, pb_out_r, pb_oe_r, pd_out_r, pd_oe_r, kbd_r;
    logic [2:0] pe_out_r, pe_oe_r;
    logic [3:0] lcd_out_r, lcd_oe_r;
    logic [1:0] card_r;
    logic       pa_card_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_out_r  <= '0;
            pa_oe_r   <= 8'hff;
            pb_out_r  <= '0;
            pb_oe_r   <= 8'hff;
            pd_out_r  <= '0;
            pd_oe_r   <= 8'hff;
            pe_out_r  <= '0;
            pe_oe_r   <= 3'h7;
            lcd_out_r <= '0;
            lcd_oe_r  <= 4'hf;
            card_r    <= '0;
            pa_card_r <= 1'b0;
            kbd_r     <= '0;
        end else begin
            pa_out_r  <= pa_data_r;
            pa_oe_r   <= ~pa_dir_r;
            pb_out_r  <= pb_data_r;
            pb_oe_r   <= pb_oe_nxt;
            pd_out_r  <= pd_out_nxt;
            pd_oe_r   <= pd_oe_nxt;
            pe_out_r  <= pe_data_r;
            pe_oe_r   <= pe_oe_nxt;
            lcd_out_r <= lcd_display_data;
            lcd_oe_r  <= lcd_oe_nxt;
            card_r    <= card_nxt;
            pa_card_r <= pa_s[7];
            kbd_r     <= pa_s;
        end
    end

    assign pready            = pready_r;
    assign prdata            = prdata_r;
    assign pslverr           = pslverr_r;
    assign port_a_pins_out   = pa_out_r;
    assign port_a_pins_oe_n  = pa_oe_r;
    assign port_b_pins_out   = pb_out_r;
    assign port_b_pins_oe_n  = pb_oe_r;
    assign port_d_pins_out   = pd_out_r;
    assign port_d_pins_oe_n  = pd_oe_r;
    assign port_e_pins_out   = pe_out_r;
    assign port_e_pins_oe_n  = pe_oe_r;
    assign lcd_pins_out      = lcd_out_r;
    assign lcd_pins_oe_n     = lcd_oe_r;
    assign card_ready_input  = card_r;
    assign port_a_card_ready = pa_card_r;
    assign keyboard_rows     = kbd_r;
    assign strap             = strap_r;
    assign strap_valid       = st_done;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pb_gpio;
        !sysc2_r[0] && pb_dir_r[0] |=> !port_b_pins_oe_n[0];
    endproperty
    a_pb_gpio: assert property (p_pb_gpio) else $error("B0 not driven as GPIO");

    property p_card_oe;
        sysc2_r[1] |=> port_b_pins_oe_n[1] && card_ready_input[1] == $past(pb_s[1]);
    endproperty
    a_card_oe: assert property (p_card_oe) else $error("B1 card ready wrong");

    property p_boot_width;
        st_cap |=> strap_r.boot_width == $past(pe_s[1:0]);
    endproperty
    a_boot_width: assert property (p_boot_width) else $error("Boot width not captured");

    property p_pll;
        st_cap |=> strap_r.pll_mode == $past(pe_s[2]) && strap_valid;
    endproperty
    a_pll: assert property (p_pll) else $error("PLL mode not captured");

    property p_pe_por;
        !st_done |=> port_e_pins_oe_n == 3'h7;
    endproperty
    a_pe_por: assert property (p_pe_por) else $error("Port E driven during strap");

    property p_pe_gpio;
        st_done ##1 st_done |-> port_e_pins_oe_n == ~$past(pe_dir_r)
                                && port_e_pins_out == $past(pe_data_r);
    endproperty
    a_pe_gpio: assert property (p_pe_gpio) else $error("Port E GPIO wrong");

    property p_led;
        ledsel_r |=> port_d_pins_out[0] == $past(led_flasher_output) && !port_d_pins_oe_n[0];
    endproperty
    a_led: assert property (p_led) else $error("LED flasher not on D0");

    property p_kbd;
        1'b1 |=> keyboard_rows == $past(pa_s) && port_a_card_ready == $past(pa_s[7]);
    endproperty
    a_kbd: assert property (p_kbd) else $error("Port A shared inputs wrong");

    property p_lcd;
        !st_done |=> lcd_pins_oe_n == 4'hf;
    endproperty
    a_lcd: assert property (p_lcd) else $error("LCD pins driven before capture");

    property p_strap_hold;
        st_done |=> $stable(strap_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("Strap changed after capture");

    property p_apb_ans;
        psel && penable && !pready_r |=> pready ##1 !pready;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("APB answer timing wrong");

    c_card: cover property (sysc2_r[0] && card_ready_input[0]);
    c_led:  cover property (ledsel_r && led_flasher_output);
    c_wr:   cover property (wr_ev && hit_per);
    c_err:  cover property (pready && pslverr);

endmodule : gpsh_top
`default_nettype wire

// ---- verification/gpsh_pin_model.sv ----
// Purpose: Pad model for straps, card adapters, keyboard rows and LCD id
// Assumes: a released pad settles to the level the bench sets for it
// Notes:   A pad follows the device whenever its enable is low
`timescale 1ns/1ps
`default_nettype none
module gpsh_pin_model (
    input  wire logic [7:0] ext_a,
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_d,
    input  wire logic [2:0] ext_e,
    input  wire logic [3:0] ext_lcd,
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe_n,
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe_n,
    input  wire logic [7:0] d_out,
    input  wire logic [7:0] d_oe_n,
    input  wire logic [2:0] e_out,
    input  wire logic [2:0] e_oe_n,
    input  wire logic [3:0] l_out,
    input  wire logic [3:0] l_oe_n,
    output logic      [7:0] a_in,
    output logic      [7:0] b_in,
    output logic      [7:0] d_in,
    output logic      [2:0] e_in,
    output logic      [3:0] l_in
);
    assign a_in = (~a_oe_n & a_out) | (a_oe_n & ext_a);
    assign b_in = (~b_oe_n & b_out) | (b_oe_n & ext_b);
    assign d_in = (~d_oe_n & d_out) | (d_oe_n & ext_d);
    assign e_in = (~e_oe_n & e_out) | (e_oe_n & ext_e);
    assign l_in = (~l_oe_n & l_out) | (l_oe_n & ext_lcd);
endmodule : gpsh_pin_model
`default_nettype wire

// ---- verification/gpio_strap_and_pin_sharing_test.sv ----
// Purpose: Self-checking bench for port sharing and strap capture
// Assumes: APB answers with pready; pads come from gpsh_pin_model
// Notes:   Register reads are checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
module gpio_strap_and_pin_sharing_test;
    import gpsh_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, led = 0;
    logic [7:0] paddr = 0, ea = 0, eb = 0, ed = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [2:0] ee = 0;
    logic [3:0] el = 0, lcd_dd = 0;
    logic pready, pslverr, strap_valid, pa_rdy;
    logic [7:0] a_i, a_o, a_n, b_i, b_o, b_n, d_i, d_o, d_n, kb;
    logic [2:0] e_i, e_o, e_n;
    logic [3:0] l_i, l_o, l_n;
    logic [1:0] crdy;
    gpsh_strap_s strap;
    logic [33:0] q[$];
    logic [33:0] ex;
    int bad_count = 0, n_checks = 0, seed = 5;
    logic [7:0] r;

    always #5 pclk = ~pclk;

    gpsh_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .port_a_pins_in(a_i), .port_a_pins_out(a_o),
        .port_a_pins_oe_n(a_n), .port_b_pins_in(b_i), .port_b_pins_out(b_o),
        .port_b_pins_oe_n(b_n), .port_d_pins_in(d_i), .port_d_pins_out(d_o),
        .port_d_pins_oe_n(d_n), .port_e_pins_in(e_i), .port_e_pins_out(e_o),
        .port_e_pins_oe_n(e_n), .lcd_pins_in(l_i), .lcd_pins_out(l_o),
        .lcd_pins_oe_n(l_n), .lcd_display_data(lcd_dd), .led_flasher_output(led),
        .card_ready_input(crdy), .port_a_card_ready(pa_rdy), .keyboard_rows(kb),
        .strap(strap), .strap_valid(strap_valid));

    gpsh_pin_model pads (.ext_a(ea), .ext_b(eb), .ext_d(ed), .ext_e(ee), .ext_lcd(el),
        .a_out(a_o), .a_oe_n(a_n), .b_out(b_o), .b_oe_n(b_n), .d_out(d_o), .d_oe_n(d_n),
        .e_out(e_o), .e_oe_n(e_n), .l_out(l_o), .l_oe_n(l_n), .a_in(a_i), .b_in(b_i),
        .d_in(d_i), .e_in(e_i), .l_in(l_i));

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // Queue entry: read flag, error flag, read data
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic e, input logic [31:0] x);
        int n;
        q.push_back({~w, e, x});
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 0;
        penable <= 0;
    endtask : apb

    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            ex = q.pop_front();
            chk({31'h0, pslverr}, {31'h0, ex[32]});
            if (ex[33])
                chk(prdata, ex[31:0]);
        end
    end

    // Reset with strap levels held until capture
    task boot(input logic [2:0] e, input logic a6, input logic [3:0] l);
        int n;
        presetn <= 0;
        ee <= e;
        ea <= {1'b0, a6, 6'h0};
        el <= l;
        cyc(3);
        presetn <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (strap_valid !== 1'b1 && n < 20);
        cyc(2);
    endtask : boot

    initial begin
        #200000;
        bad_count++;
        close_out();
    end

    initial begin
        lcd_dd = 4'h6;
        boot(3'h5, 1'b1, 4'ha);
        chk(strap, 8'had);
        apb(0, GPSH_OFF_STRAP, 0, 0, 32'h1ad);
        apb(1, GPSH_OFF_STRAP, 32'hff, 1, 0);
        chk(l_n, 4'h0);
        chk(l_o, lcd_dd);
        ee <= 3'h2;
        ea <= 8'h00;
        el <= 4'h3;
        cyc(6);
        chk(strap, 8'had);
        // Port B as plain outputs, then read back from the pins
        r = $random(seed);
        apb(1, GPSH_OFF_PB_DIR, 32'hff, 0, 0);
        apb(1, GPSH_OFF_PB_DATA, {24'h0, r}, 0, 0);
        cyc(3);
        chk(b_n, 8'h00);
        chk(b_o, r);
        apb(0, GPSH_OFF_PB_DATA, 0, 0, {24'h0, r});
        // Card control bits take over bits 0 and 1
        eb <= 8'h02;
        apb(1, GPSH_OFF_SYSC2, 32'h3, 0, 0);
        cyc(5);
        chk(b_n[1:0], 2'b11);
        chk(crdy, 2'b10);
        eb <= 8'h01;
        cyc(5);
        chk(crdy, 2'b01);
        apb(1, GPSH_OFF_SYSC2, 32'h0, 0, 0);
        cyc(5);
        chk(b_n[1:0], 2'b00);
        chk(crdy, 2'b00);
        // LED flasher shares port D bit 0
        apb(1, GPSH_OFF_LEDSEL, 32'h1, 0, 0);
        led <= 1;
        cyc(3);
        chk({d_n[0], d_o[0]}, 2'b01);
        led <= 0;
        cyc(3);
        chk({d_n[0], d_o[0]}, 2'b00);
        apb(1, GPSH_OFF_LEDSEL, 32'h0, 0, 0);
        cyc(3);
        chk(d_n[0], 1'b1);
        // Port E drives three bits after strap capture
        apb(1, GPSH_OFF_PE_DIR, 32'h7, 0, 0);
        apb(1, GPSH_OFF_PE_DATA, 32'h5, 0, 0);
        cyc(4);
        chk({e_n, e_o}, 6'h05);
        apb(0, GPSH_OFF_PE_DATA, 0, 0, 32'h5);
        chk(strap, 8'had);
        // Keyboard rows and live card ready on port A
        r = $random(seed);
        ea <= r;
        cyc(5);
        chk(kb, r);
        chk(pa_rdy, r[7]);
        apb(0, GPSH_OFF_PA_DATA, 0, 0, {24'h0, r});
        apb(0, 8'h2c, 0, 1, 0);
        // Second power-on reset captures new straps
        boot(3'h2, 1'b0, 4'h3);
        chk(strap, 8'h32);
        cyc(3);
        close_out();
    end
endmodule : gpio_strap_and_pin_sharing_test
`default_nettype wire
